//--- src/bju_pkg.sv
// Purpose: shared constants, types and timing tables for the branch unit
// Assumes: 40 MHz hclk, one machine cycle per hclk
// Notes: offsets are byte addresses on the AHB-Lite slave
package bju_pkg;
  // ----------------------------------------
  // clock and register map
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000; // hclk rate
  localparam logic [7:0] OFS_CTRL = 8'h00; // op code and start
  localparam logic [7:0] OFS_FLAGS = 8'h04; // condition flags
  localparam logic [7:0] OFS_ACC = 8'h08; // accumulator
  localparam logic [7:0] OFS_IMM = 8'h0C; // immediate / displacement
  localparam logic [7:0] OFS_MEM = 8'h10; // long word at effective address
  localparam logic [7:0] OFS_PC = 8'h14; // program counter
  localparam logic [7:0] OFS_BANK = 8'h18; // code bank
  localparam logic [7:0] OFS_SP = 8'h1C; // stack pointer
  localparam logic [7:0] OFS_STATUS = 8'h20; // busy, done, taken
  localparam logic [7:0] OFS_PUSHED = 8'h24; // last pushed data
  // field positions
  localparam int unsigned CTRL_START_BIT = 8;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_TAKEN_BIT = 2;
  // reset values
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [15:0] RST_SP = 16'h0000;
  localparam logic [15:0] PUSH_WORD = 16'h0002; // bytes per word push
  localparam logic [15:0] PUSH_LONG = 16'h0004; // bytes per long push
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_BR_FIRST = 5'h00, // 0x00..0x0F conditional, pairs true/false
    OP_BRANCH_ALWAYS = 5'h10, OP_JMP_ACC = 5'h11, OP_JMP_ABS16 = 5'h12,
    OP_JMP_REG = 5'h13, OP_JMP_MEM = 5'h14, OP_FAR_JUMP_REG = 5'h15,
    OP_FAR_JUMP_MEM = 5'h16, OP_FAR_JUMP_ABS = 5'h17, OP_CALL_REG = 5'h18,
    OP_CALL_MEM = 5'h19, OP_CALL_ABS16 = 5'h1A, OP_FAR_CALL_REG = 5'h1B,
    OP_FAR_CALL_MEM = 5'h1C, OP_FAR_CALL_ABS = 5'h1D
  } op_e;
  typedef struct packed {logic t; logic n; logic z; logic v; logic c;} flags_s;
  typedef struct packed {logic en; logic is_long; logic [15:0] addr; logic [31:0] data;} push_s;
  // ----------------------------------------
  // length in bytes and machine cycles
  // ----------------------------------------
  function automatic logic [15:0] op_len(input logic [4:0] op);
    op_len = 16'h0002;
    case (op)
      OP_JMP_ACC: op_len = 16'h0001;
      OP_JMP_ABS16, OP_CALL_ABS16: op_len = 16'h0003;
      OP_FAR_JUMP_ABS, OP_FAR_CALL_ABS: op_len = 16'h0004;
      default: op_len = 16'h0002;
    endcase
  endfunction
  function automatic logic [3:0] op_cycles(input logic [4:0] op, input logic take);
    case (op)
      OP_JMP_ACC: op_cycles = 4'h2;
      OP_JMP_ABS16, OP_JMP_REG: op_cycles = 4'h3;
      OP_JMP_MEM, OP_FAR_JUMP_ABS: op_cycles = 4'h4;
      OP_FAR_JUMP_REG: op_cycles = 4'h5;
      OP_FAR_JUMP_MEM, OP_CALL_REG, OP_CALL_ABS16: op_cycles = 4'h6;
      OP_CALL_MEM: op_cycles = 4'h7;
      OP_FAR_CALL_REG, OP_FAR_CALL_ABS: op_cycles = 4'hA;
      OP_FAR_CALL_MEM: op_cycles = 4'hB;
      default: op_cycles = take ? 4'h4 : 4'h3; // relative branches
    endcase
  endfunction
endpackage

//--- src/branch_cond.sv
// Purpose: flag condition test for the relative branches
// Assumes: even codes test a condition, odd codes its inverse
// Notes: purely combinational, flags are only read here
`timescale 1ns/1ps
module branch_cond import bju_pkg::*; (
  // condition select
  input wire logic [3:0] cond,
  input wire flags_s flags,
  // result
  output logic take
);
  logic base; // condition before inversion
  // pick the base condition, then invert for odd codes
  always_comb begin
    case (cond[3:1])
      3'h0: base = flags.z; // RQ1
      3'h1: base = flags.c; // RQ2
      3'h2: base = flags.n; // RQ3
      3'h3: base = flags.v; // RQ4
      3'h4: base = flags.t; // RQ5
      3'h5: base = flags.v ^ flags.n; // RQ6
      3'h6: base = (flags.v ^ flags.n) | flags.z; // RQ7
      3'h7: base = flags.c | flags.z; // RQ8
      default: base = 1'b0;
    endcase
    take = base ^ cond[0];
  end
endmodule

//--- src/cycle_count.sv
// Purpose: down counter that times one instruction in machine cycles
// Assumes: load and count never overlap a running count
// Notes: last is high in the final counted cycle
`timescale 1ns/1ps
module cycle_count #(parameter int unsigned W = 4) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // state
  output logic [W-1:0] cnt_q,
  output logic last
);
  // load wins, else count down to zero and stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end
  assign last = (cnt_q == W'(1));
endmodule

//--- src/branch_jump_call_unit.sv
// Purpose: branch, jump and call execution for a 16-bit core, AHB-Lite regs
// Assumes: single-word transfers, one hclk per machine cycle
// Notes: flags, operands and stack pointer are software-visible registers
//
// How it works
// RQ1: zero flag selects zero/not-zero branch
// RQ2: carry flag selects carry/no-carry branch
// RQ3: negative flag selects negative/positive branch
// RQ4: overflow flag selects overflow branches
// RQ5: sticky flag selects sticky branches
// RQ6: overflow xor negative gives signed less
// RQ7: add zero for signed less-or-equal
// RQ8: carry or zero gives unsigned lower-same
// RQ9: branch takes four cycles, else three
// RQ10: accumulator jump loads pc, two cycles
// RQ11: absolute jump loads pc, bank kept
// RQ12: far indirect loads pc and bank
// RQ13: far absolute splits 24-bit immediate
// RQ14: near call pushes word, loads pc
// RQ15: far call pushes long, loads both
// RQ16: indirect far call reads long target
// RQ17: relative target is next plus displacement
// RQ18: flags never changed by execution
`timescale 1ns/1ps
module branch_jump_call_unit import bju_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core side
  output logic [15:0] pc_out,
  output logic [7:0] code_bank_out,
  output logic busy_out,
  output push_s push_out
);
  // ----------------------------------------
  // state and registers
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} state_e;
  state_e state_q; // execution state
  logic wr_pend_q; // write data phase pending
  logic [7:0] wr_addr_q; // address of pending write
  logic hreadyout_q; // ready from the first edge after reset, zero wait
  logic [31:0] hrdata_q; // read data captured at address phase
  logic [4:0] op_q; // last launched op
  flags_s flags_q; // condition flags
  logic [31:0] acc_q; // accumulator
  logic [23:0] imm_q; // immediate or displacement
  logic [31:0] mem_q; // long operand at effective address
  logic [15:0] pc_q; // program counter
  logic [7:0] code_bank_reg_q; // code bank
  logic [15:0] sp_q; // stack pointer
  logic done_q; // last op finished
  logic taken_q; // last op transferred control
  logic [15:0] tgt_pc_q; // pc loaded at commit
  logic [7:0] tgt_bank_q; // bank loaded at commit
  push_s push_q; // stack push, one cycle
  // ----------------------------------------
  // decode of the bus
  // ----------------------------------------
  logic accept; // address phase taken
  logic wr_hit; // write data phase this cycle
  logic go; // launch of an instruction
  logic [4:0] op_in; // op from write data
  logic take; // control transfer decision
  logic cond_take; // flag condition result
  logic [15:0] next_pc; // address after the instruction
  logic [15:0] br_pc; // relative branch target
  logic is_call; // op pushes a return address
  logic is_far_call; // op pushes a long return address
  logic [3:0] cyc_cnt; // counter value
  logic cyc_last; // final counted cycle
  logic flag_wr; // flags written this cycle
  // a write commits in its data phase, one edge after the address
  assign accept = hsel && htrans[1] && hready;
  assign wr_hit = wr_pend_q;
  assign op_in = hwdata[4:0];
  assign flag_wr = wr_hit && (wr_addr_q == OFS_FLAGS);
  // unknown codes and starts during execution are ignored
  assign go = wr_hit && (wr_addr_q == OFS_CTRL) && hwdata[CTRL_START_BIT]
    && (state_q == ST_IDLE) && (op_in <= OP_FAR_CALL_ABS);
  // next_pc doubles as the near return address and the fall-through target
  assign next_pc = pc_q + op_len(op_in);
  assign br_pc = next_pc + {{8{imm_q[7]}}, imm_q[7:0]}; // RQ17
  assign is_far_call = (op_in >= OP_FAR_CALL_REG);
  assign is_call = (op_in >= OP_CALL_REG);
  // conditional codes use the flag test, everything else always transfers
  assign take = (op_in < OP_BRANCH_ALWAYS) ? cond_take : 1'b1;
  // the condition code is the low nibble of the op
  branch_cond u_cond (
    .cond(op_in[3:0]),
    .flags(flags_q),
    .take(cond_take)
  );
  // one counter times every op; a fresh load only happens from idle
  cycle_count #(.W(4)) u_count (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(go),
    .load_val(op_cycles(op_in, take)), // RQ9
    .cnt_q(cyc_cnt),
    .last(cyc_last)
  );
  // ----------------------------------------
  // ahb address phase and read data
  // ----------------------------------------
  // reads are captured when the address is taken, so data stands one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
      wr_pend_q <= accept && hwrite;
      if (accept) begin
        wr_addr_q <= haddr[7:0];
      end
      // upper bits of narrow registers read as zero
      if (accept && !hwrite) begin
        case (haddr[7:0])
          OFS_CTRL: hrdata_q <= {27'h0, op_q};
          OFS_FLAGS: hrdata_q <= {27'h0, flags_q};
          OFS_ACC: hrdata_q <= acc_q;
          OFS_IMM: hrdata_q <= {8'h00, imm_q};
          OFS_MEM: hrdata_q <= mem_q;
          OFS_PC: hrdata_q <= {16'h0000, pc_q};
          OFS_BANK: hrdata_q <= {24'h00_0000, code_bank_reg_q};
          OFS_SP: hrdata_q <= {16'h0000, sp_q};
          OFS_STATUS: hrdata_q <= {29'h0, taken_q, done_q, state_q == ST_EXEC};
          OFS_PUSHED: hrdata_q <= push_q.data;
          default: hrdata_q <= 32'h0000_0000; // unmapped reads as zero
        endcase
      end
    end
  end
  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // flags are only ever written by software, never by execution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= '0;
    end else if (flag_wr) begin
      flags_q <= hwdata[4:0]; // RQ18
    end
  end
  // operand registers are frozen while an op runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 32'h0000_0000;
      imm_q <= 24'h00_0000;
      mem_q <= 32'h0000_0000;
    end else if (wr_hit && state_q == ST_IDLE) begin
      case (wr_addr_q)
        OFS_ACC: acc_q <= hwdata;
        OFS_IMM: imm_q <= hwdata[23:0];
        OFS_MEM: mem_q <= hwdata;
        default: acc_q <= acc_q;
      endcase
    end
  end
  // ----------------------------------------
  // launch: target, push, state
  // ----------------------------------------
  // target is fixed at launch so later operand writes cannot disturb it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_pc_q <= RST_PC;
      tgt_bank_q <= RST_BANK;
      op_q <= 5'h00;
      taken_q <= 1'b0;
    end else if (go) begin
      op_q <= op_in;
      taken_q <= take;
      tgt_bank_q <= code_bank_reg_q;
      case (op_in)
        OP_JMP_ACC: tgt_pc_q <= acc_q[15:0]; // RQ10
        OP_JMP_ABS16, OP_CALL_ABS16: tgt_pc_q <= imm_q[15:0]; // RQ11
        OP_JMP_REG, OP_JMP_MEM, OP_CALL_REG, OP_CALL_MEM: tgt_pc_q <= mem_q[15:0]; // RQ14
        OP_FAR_JUMP_REG, OP_FAR_JUMP_MEM: begin
          tgt_pc_q <= mem_q[15:0]; // RQ12
          tgt_bank_q <= mem_q[23:16]; // RQ12
        end
        OP_FAR_CALL_REG, OP_FAR_CALL_MEM: begin
          tgt_pc_q <= mem_q[15:0]; // RQ16
          tgt_bank_q <= mem_q[23:16]; // RQ16
        end
        OP_FAR_JUMP_ABS, OP_FAR_CALL_ABS: begin
          tgt_pc_q <= imm_q[15:0]; // RQ13
          tgt_bank_q <= imm_q[23:16]; // RQ15
        end
        default: tgt_pc_q <= take ? br_pc : next_pc; // RQ17
      endcase
    end
  end
  // return address goes to the stack in the cycle after launch, before the pc moves
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      push_q <= '0;
      sp_q <= RST_SP;
    end else if (go && is_call) begin
      push_q.en <= 1'b1;
      push_q.is_long <= is_far_call;
      if (is_far_call) begin
        push_q.addr <= sp_q - PUSH_LONG; // RQ15
        push_q.data <= {8'h00, code_bank_reg_q, next_pc}; // RQ15
        sp_q <= sp_q - PUSH_LONG;
      end else begin
        push_q.addr <= sp_q - PUSH_WORD; // RQ14
        push_q.data <= {16'h0000, next_pc}; // RQ14
        sp_q <= sp_q - PUSH_WORD;
      end
    end else begin
      push_q.en <= 1'b0;
      if (wr_hit && state_q == ST_IDLE && wr_addr_q == OFS_SP) begin
        sp_q <= hwdata[15:0];
      end
    end
  end
  // busy for exactly the op's cycle count, pc and bank move on the last edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      done_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (go) begin
            state_q <= ST_EXEC;
            done_q <= 1'b0;
          end
        end
        ST_EXEC: begin
          if (cyc_last) begin
            state_q <= ST_IDLE; // RQ9
            done_q <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // program counter and bank: commit from execution, else software in idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pc_q <= RST_PC;
      code_bank_reg_q <= RST_BANK;
    end else if (state_q == ST_EXEC && cyc_last) begin
      pc_q <= tgt_pc_q;
      code_bank_reg_q <= tgt_bank_q;
    end else if (wr_hit && state_q == ST_IDLE && !go) begin
      if (wr_addr_q == OFS_PC) begin
        pc_q <= hwdata[15:0];
      end
      if (wr_addr_q == OFS_BANK) begin
        code_bank_reg_q <= hwdata[7:0];
      end
    end
  end
  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0; // always okay; constant, no state behind it
  assign hrdata = hrdata_q;
  assign pc_out = pc_q;
  assign code_bank_out = code_bank_reg_q;
  // busy is the exec bit of the one-hot state, so it needs no decode
  assign busy_out = state_q[1];
  assign push_out = push_q;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic busy; // execution in progress
  assign busy = (state_q == ST_EXEC);
  // the commit lands on the last counted edge, so it is sampled one edge later:
  // an op of n cycles launched at edge 0 shows its new pc at edge n+1
  // operand registers are frozen while busy, so $past of them still names the
  // values that were live at launch
  a_zero_taken: assert property (go && op_in == 5'h00 && flags_q.z |=> busy[*4] ##1 !busy) // RQ1
    else $error("zero branch not taken in four cycles");
  a_carry_fall: assert property (go && op_in == 5'h02 && !flags_q.c |=> busy[*3] ##1 !busy) // RQ2
    else $error("carry branch did not fall through");
  a_neg_taken: assert property (go && op_in == 5'h05 && !flags_q.n |-> ##4 taken_q) // RQ3
    else $error("positive branch not taken");
  a_ovf_taken: assert property (go && op_in == 5'h06 && flags_q.v |-> ##4 taken_q) // RQ4
    else $error("overflow branch not taken");
  a_sticky_fall: assert property (go && op_in == 5'h08 && !flags_q.t |=> !taken_q) // RQ5
    else $error("sticky branch taken without sticky");
  a_signed_less: assert property (go && op_in == 5'h0A |=> taken_q == $past(flags_q.v ^ flags_q.n)) // RQ6
    else $error("signed less decision wrong");
  a_signed_le: assert property (go && op_in == 5'h0D
    |=> taken_q == !$past((flags_q.v ^ flags_q.n) | flags_q.z)) // RQ7
    else $error("signed greater decision wrong");
  a_unsigned_le: assert property (go && op_in == 5'h0E |=> taken_q == $past(flags_q.c | flags_q.z)) // RQ8
    else $error("unsigned lower-same decision wrong");
  a_always_len: assert property (go && op_in == OP_BRANCH_ALWAYS |=> busy[*4] ##1 !busy) // RQ9
    else $error("unconditional branch not four cycles");
  a_acc_jump: assert property (go && op_in == OP_JMP_ACC
    |-> ##3 pc_q == $past(acc_q[15:0], 3) && code_bank_reg_q == $past(code_bank_reg_q, 3) && !busy) // RQ10
    else $error("accumulator jump wrong pc or timing");
  a_abs_jump: assert property (go && op_in == OP_JMP_ABS16
    |-> ##4 pc_q == $past(imm_q[15:0], 4) && code_bank_reg_q == $past(code_bank_reg_q, 4)) // RQ11
    else $error("absolute jump wrong pc or bank");
  a_far_ind: assert property (go && op_in == OP_FAR_JUMP_REG
    |-> ##6 pc_q == $past(mem_q[15:0], 6) && code_bank_reg_q == $past(mem_q[23:16], 6)) // RQ12
    else $error("far indirect jump wrong target");
  a_far_abs: assert property (go && op_in == OP_FAR_JUMP_ABS
    |-> ##5 pc_q == $past(imm_q[15:0], 5) && code_bank_reg_q == $past(imm_q[23:16], 5)) // RQ13
    else $error("far absolute jump wrong target");
  a_near_push: assert property (go && op_in == OP_CALL_ABS16
    |=> push_q.en && !push_q.is_long && push_q.data[15:0] == $past(next_pc)
    ##6 pc_q == $past(imm_q[15:0], 7)) // RQ14
    else $error("near call push or target wrong");
  a_far_push: assert property (go && op_in == OP_FAR_CALL_ABS
    |=> push_q.en && push_q.is_long && push_q.data[23:16] == $past(code_bank_reg_q)) // RQ15
    else $error("far call push wrong");
  a_far_call_ind: assert property (go && op_in == OP_FAR_CALL_MEM
    |-> ##12 code_bank_reg_q == $past(mem_q[23:16], 12)) // RQ16
    else $error("indirect far call wrong bank");
  a_rel_target: assert property (go && op_in == OP_BRANCH_ALWAYS
    |-> ##5 pc_q == $past(br_pc, 5)) // RQ17
    else $error("relative target wrong");
  a_flags_kept: assert property (!flag_wr |=> $stable(flags_q)) // RQ18
    else $error("flags changed without a write");
  // covers: taken and fall-through branches, both call widths, a plain jump
  c_branch_taken: cover property (go && op_in < OP_BRANCH_ALWAYS && take);
  c_branch_fall: cover property (go && op_in < OP_BRANCH_ALWAYS && !take);
  c_far_call: cover property (go && op_in == OP_FAR_CALL_REG ##1 push_q.en);
  c_near_call: cover property (go && op_in == OP_CALL_MEM);
  c_acc_jump: cover property (go && op_in == OP_JMP_ACC);
endmodule

//--- tb/branch_jump_call_unit_tb_top.sv
// Purpose: self-checking bench for the branch, jump and call unit over ahb-lite
// Assumes: zero-wait slave, hready looped back from hreadyout, 40 MHz hclk
// Notes: expectations come from bench functions; random operands from a fixed seed
`timescale 1ns/1ps
module branch_jump_call_unit_tb_top import bju_pkg::*;;
  // ----------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------
  logic hclk = 1'b0; // bus clock
  logic hresetn = 1'b0; // active low reset
  logic hsel = 1'b0, hwrite = 1'b0; // select and direction
  logic [1:0] htrans = 2'b00; // transfer kind
  logic [2:0] hsize = 3'b010; // always a word
  logic [31:0] haddr = 32'h0, hwdata = 32'h0; // address and write data
  wire hready; // loop-back of the slave's ready
  logic hreadyout, hresp; // slave answer
  logic [31:0] hrdata; // read data
  logic [15:0] pc_out; // program counter
  logic [7:0] code_bank_out; // code bank
  logic busy_out; // execution in progress
  push_s push_out, plast; // stack push and last one seen
  int errors = 0, tests_run = 0, pcnt = 0; // counters
  integer seed = 32'h62d9; // fixed seed keeps runs repeatable
  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  branch_jump_call_unit u_branch_jump_call_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pc_out(pc_out), .code_bank_out(code_bank_out), .busy_out(busy_out),
    .push_out(push_out));
  // capture every push pulse; en stands one cycle only
  always @(posedge hclk) begin
    if (push_out.en === 1'b1) begin
      pcnt <= pcnt + 1;
      plast <= push_out;
    end
  end
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(25 * 20000);
    errors++;
    complete_run();
  end
  // ----------------------------------------
  // ahb-lite master, single word transfers
  // ----------------------------------------
  task automatic wait_ready();
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1); // the watchdog ends a wait on a dead slave
  endtask
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus_xfer(1'b1, a, d, dummy);
  endtask
  // ----------------------------------------
  // reference behaviour
  // ----------------------------------------
  function automatic logic take_ref(input logic [3:0] c, input logic [4:0] f);
    logic t, n, z, v, cy, x;
    {t, n, z, v, cy} = f;
    case (c[3:1])
      3'h0: x = z;
      3'h1: x = cy;
      3'h2: x = n;
      3'h3: x = v;
      3'h4: x = t;
      3'h5: x = v ^ n;
      3'h6: x = (v ^ n) | z;
      default: x = cy | z;
    endcase
    return c[0] ? ~x : x; // odd codes test the inverse
  endfunction
  function automatic int exp_cyc(input logic [4:0] op, input logic tk);
    int tbl [14] = '{2, 3, 3, 4, 5, 6, 4, 6, 7, 6, 10, 11, 10, 0};
    if (op <= 5'h10) return tk ? 4 : 3;
    return tbl[op - 5'h11];
  endfunction
  function automatic logic [15:0] op_bytes(input logic [4:0] op);
    if (op == 5'h11) return 16'h0001;
    if (op == 5'h12 || op == 5'h1A) return 16'h0003;
    if (op == 5'h17 || op == 5'h1D) return 16'h0004;
    return 16'h0002;
  endfunction
  // ----------------------------------------
  // one instruction with random operands; k selects a displacement corner
  // ----------------------------------------
  task automatic exec_op(input logic [4:0] op, input int k);
    logic [31:0] fl, acc, imm, mem, rd, pd;
    logic [15:0] pc, sp, npc, tgt;
    logic [7:0] bank, tbank;
    logic tk, far;
    int n, p0;
    fl = $random(seed) & 32'h1F;
    acc = $random(seed);
    imm = $random(seed) & 32'hFFFFFF;
    mem = $random(seed);
    pc = $random(seed);
    bank = $random(seed);
    sp = $random(seed);
    if (k == 0) imm[7:0] = 8'h80; // most negative displacement
    if (k == 1) begin
      imm[7:0] = 8'h7F; // most positive, with pc wrap
      pc = 16'hFFFE;
    end
    bus_wr(OFS_FLAGS, fl);
    bus_wr(OFS_ACC, acc);
    bus_wr(OFS_IMM, imm);
    bus_wr(OFS_MEM, mem);
    bus_wr(OFS_PC, {16'h0, pc});
    bus_wr(OFS_BANK, {24'h0, bank});
    bus_wr(OFS_SP, {16'h0, sp});
    tk = (op >= 5'h10) ? 1'b1 : take_ref(op[3:0], fl[4:0]);
    npc = pc + op_bytes(op);
    tgt = npc;
    tbank = bank;
    case (op)
      5'h11: tgt = acc[15:0];
      5'h12, 5'h1A: tgt = imm[15:0];
      5'h13, 5'h14, 5'h18, 5'h19: tgt = mem[15:0];
      5'h15, 5'h16, 5'h1B, 5'h1C: {tbank, tgt} = mem[23:0];
      5'h17, 5'h1D: {tbank, tgt} = imm[23:0];
      default: if (tk) tgt = npc + {{8{imm[7]}}, imm[7:0]};
    endcase
    p0 = pcnt;
    bus_wr(OFS_CTRL, 32'h100 | op);
    n = 0;
    // busy rises at the launch edge itself, so the first look is just after it
    for (int i = 0; i < 40; i++) begin
      #1;
      if (busy_out === 1'b1) n++;
      else if (n > 0) break;
      @(posedge hclk);
    end
    chk("cycles", n, exp_cyc(op, tk));
    chk("pc", pc_out, tgt);
    chk("bank", code_bank_out, tbank);
    bus_xfer(1'b0, OFS_FLAGS, 32'h0, rd);
    chk("flags", rd, fl);
    if (op >= 5'h18) begin
      far = (op >= 5'h1B);
      pd = far ? {8'h00, bank, npc} : {16'h0, npc};
      chk("push count", pcnt - p0, 1);
      chk("push long", plast.is_long, far);
      chk("push addr", plast.addr, sp - (far ? 16'h4 : 16'h2));
      chk("push data", plast.data, pd);
      bus_xfer(1'b0, OFS_SP, 32'h0, rd);
      chk("sp", rd, {16'h0, sp - (far ? 16'h4 : 16'h2)});
    end else begin
      chk("no push", pcnt - p0, 0);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic [15:0] pkeep;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("reset pc", pc_out, RST_PC);
    chk("reset bank", code_bank_out, RST_BANK);
    chk("reset busy", busy_out, 1'b0);
    chk("hresp", hresp, 1'b0);
    bus_xfer(1'b0, OFS_SP, 32'h0, rd);
    chk("reset sp", rd, {16'h0, RST_SP});
    bus_xfer(1'b0, 8'h40, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // every code twice with displacement corners, then random codes
    for (int k = 0; k < 2; k++) begin
      for (int op = 0; op < 30; op++) exec_op(op[4:0], k);
    end
    for (int r = 0; r < 40; r++) exec_op(($random(seed) & 32'h7FFFFFFF) % 30, 2);
    // a direct pc write during a far call is refused
    bus_wr(OFS_IMM, 32'h00ABCDEF);
    bus_wr(OFS_CTRL, 32'h11D);
    bus_wr(OFS_PC, 32'h1234);
    for (int i = 0; i < 20 && busy_out !== 1'b0; i++) @(posedge hclk);
    #1;
    chk("refused pc", pc_out, 16'hCDEF);
    chk("refused bank", code_bank_out, 8'hAB);
    // an unknown code does not start anything
    pkeep = pc_out;
    bus_wr(OFS_CTRL, 32'h11E);
    repeat (3) @(posedge hclk);
    #1;
    chk("bad code busy", busy_out, 1'b0);
    chk("bad code pc", pc_out, pkeep);
    complete_run();
  end
endmodule
